// ===== include/qdec_defs.svh
`ifndef QDEC_DEFS_SVH
`define QDEC_DEFS_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define QD_AW            4
`define QD_DW            32

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define QD_OFS_CTRL      4'h0
`define QD_OFS_POS       4'h4
`define QD_OFS_PMAX      4'h8
`define QD_OFS_STS       4'hC

// ----------------------------------------------------------------
// Register selector codes
// ----------------------------------------------------------------
`define QD_SEL_CTRL      3'h0
`define QD_SEL_POS       3'h1
`define QD_SEL_PMAX      3'h2
`define QD_SEL_STS       3'h3
`define QD_SEL_NONE      3'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define QD_CTRL_MODE_LO  0
`define QD_CTRL_MODE_HI  1
`define QD_CTRL_CNT_EN   2
`define QD_STS_FIRST     0
`define QD_STS_FDIR      1
`define QD_STS_DIR       2
`define QD_STS_PHERR     3
`define QD_STS_EDGE_LO   4
`define QD_STS_EDGE_HI   5

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define QD_MODE_INDEX    2'h0
`define QD_RESP_OKAY     2'h0
`define QD_RESP_SLVERR   2'h2
`define QD_POS_ZERO      32'h0000_0000
`define QD_POS_ONE       32'h0000_0001

// Input vector bit positions
`define QD_IN_A          0
`define QD_IN_B          1
`define QD_IN_I          2

`endif

// ===== include/qdec_pkg.sv
package qdec_pkg;

    typedef enum logic [1:0]
    {
        IDX_IDLE  = 2'b00,
        IDX_ARMED = 2'b01,
        IDX_DONE  = 2'b10
    } idx_state_t;

    typedef struct packed
    {
        logic [2:0]  in_s1;
        logic [2:0]  in_s2;
        logic [1:0]  ab_prev;
        logic [1:0]  mode;
        logic        cnt_en;
        logic [31:0] pos;
        logic [31:0] pmax;
        logic        first_seen;
        logic        first_dir;
        logic        dir_fwd;
        logic        ph_err;
        logic [1:0]  edge_code;
        idx_state_t  idx_st;
        logic        rst_pend;
        logic        rst_fwd;
        logic        awready;
        logic        aw_have;
        logic [3:0]  awaddr;
        logic        wready;
        logic        w_have;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } state_t;

endpackage

// ===== hw/quadrature_index_position_reset.sv
`include "qdec_defs.svh"

module quadrature_index_position_reset
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        phase_a,
    input  wire logic        phase_b,
    input  wire logic        index_in,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] reg_sel(input logic [3:0] addr);
        case (addr)
            `QD_OFS_CTRL: reg_sel = `QD_SEL_CTRL;
            `QD_OFS_POS:  reg_sel = `QD_SEL_POS;
            `QD_OFS_PMAX: reg_sel = `QD_SEL_PMAX;
            `QD_OFS_STS:  reg_sel = `QD_SEL_STS;
            default:      reg_sel = `QD_SEL_NONE;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge = r;
    endfunction

    qdec_pkg::state_t st_q;
    qdec_pkg::state_t st_d;

    logic [1:0]  ab_now;
    logic [1:0]  ab_diff;
    logic        edge_ok;
    logic        edge_bad;
    logic        fwd_now;
    logic [1:0]  code_now;
    logic        idx_now;
    logic [31:0] sts_word;
    logic [31:0] ctrl_word;
    logic [31:0] ctrl_wr;

    always_comb
    begin
        ab_now   = {st_q.in_s2[`QD_IN_B], st_q.in_s2[`QD_IN_A]};
        idx_now  = st_q.in_s2[`QD_IN_I];
        ab_diff  = ab_now ^ st_q.ab_prev;
        edge_ok  = ab_diff[0] ^ ab_diff[1];
        edge_bad = ab_diff[0] & ab_diff[1];
        // Forward when A leads B
        fwd_now  = st_q.ab_prev[1] ^ ab_now[0];
        // Edge identity: which phase moved and its new level
        code_now = ab_diff[1] ? {1'b1, ab_now[1]} : {1'b0, ab_now[0]};

        ctrl_word = '0;
        ctrl_word[`QD_CTRL_MODE_HI:`QD_CTRL_MODE_LO] = st_q.mode;
        ctrl_word[`QD_CTRL_CNT_EN] = st_q.cnt_en;
        ctrl_wr = merge(ctrl_word, st_q.wdata, st_q.wstrb);

        sts_word = '0;
        sts_word[`QD_STS_FIRST] = st_q.first_seen;
        sts_word[`QD_STS_FDIR]  = st_q.first_dir;
        sts_word[`QD_STS_DIR]   = st_q.dir_fwd;
        sts_word[`QD_STS_PHERR] = st_q.ph_err;
        sts_word[`QD_STS_EDGE_HI:`QD_STS_EDGE_LO] = st_q.edge_code;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;

        // Only the second stage is read by logic
        st_d.in_s1   = {index_in, phase_b, phase_a};
        st_d.in_s2   = st_q.in_s1;
        st_d.ab_prev = ab_now;

        st_d.dir_fwd = edge_ok ? fwd_now : st_q.dir_fwd;
        st_d.ph_err  = st_q.ph_err | edge_bad;

        // Counting, with wrap at the maximum
        if (st_q.cnt_en && edge_ok)
        begin
            if (fwd_now)
            begin
                st_d.pos = (st_q.pos == st_q.pmax) ? `QD_POS_ZERO : st_q.pos + `QD_POS_ONE;
            end
            else
            begin
                st_d.pos = (st_q.pos == `QD_POS_ZERO) ? st_q.pmax : st_q.pos - `QD_POS_ONE;
            end
        end

        // Index reset lands one clock after the qualifying edge
        st_d.rst_pend = 1'b0;
        if (st_q.rst_pend)
        begin
            st_d.pos = st_q.rst_fwd ? `QD_POS_ZERO : st_q.pmax;
        end

        // Index tracking; only the stored edge is compared, never the
        // direction, so a reversal inside the pulse can fire off-position
        if (st_q.mode != `QD_MODE_INDEX)
        begin
            st_d.idx_st = qdec_pkg::IDX_IDLE;
        end
        else
        begin
            case (st_q.idx_st)
                qdec_pkg::IDX_IDLE:
                begin
                    if (idx_now)
                    begin
                        st_d.idx_st = qdec_pkg::IDX_ARMED;
                    end
                end
                qdec_pkg::IDX_ARMED:
                begin
                    if (!idx_now)
                    begin
                        st_d.idx_st = qdec_pkg::IDX_IDLE;
                    end
                    else if (edge_ok && !st_q.first_seen)
                    begin
                        st_d.first_seen = 1'b1;
                        st_d.first_dir  = fwd_now;
                        st_d.edge_code  = code_now;
                        st_d.rst_pend   = 1'b1;
                        st_d.rst_fwd    = fwd_now;
                        st_d.idx_st     = qdec_pkg::IDX_DONE;
                    end
                    else if (edge_ok && code_now == st_q.edge_code)
                    begin
                        // Reversal mid-pulse still matches here
                        // A clean pulse matches on the true edge
                        st_d.rst_pend = 1'b1;
                        st_d.rst_fwd  = fwd_now;
                        st_d.idx_st   = qdec_pkg::IDX_DONE;
                    end
                end
                qdec_pkg::IDX_DONE:
                begin
                    if (!idx_now)
                    begin
                        st_d.idx_st = qdec_pkg::IDX_IDLE;
                    end
                end
                default:
                begin
                    st_d.idx_st = qdec_pkg::IDX_IDLE;
                end
            endcase
        end

        // ------------------------------------------------------------
        // AXI4-Lite write path
        // ------------------------------------------------------------
        if (st_q.bvalid && s_axi_bready)
        begin
            st_d.bvalid = 1'b0;
        end
        if (st_q.awready && s_axi_awvalid)
        begin
            st_d.aw_have = 1'b1;
            st_d.awaddr  = s_axi_awaddr;
        end
        if (st_q.wready && s_axi_wvalid)
        begin
            st_d.w_have = 1'b1;
            st_d.wdata  = s_axi_wdata;
            st_d.wstrb  = s_axi_wstrb;
        end
        if (st_q.aw_have && st_q.w_have && !st_q.bvalid)
        begin
            st_d.aw_have = 1'b0;
            st_d.w_have  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = `QD_RESP_OKAY;
            case (reg_sel(st_q.awaddr))
                `QD_SEL_CTRL:
                begin
                    st_d.mode   = ctrl_wr[`QD_CTRL_MODE_HI:`QD_CTRL_MODE_LO];
                    st_d.cnt_en = ctrl_wr[`QD_CTRL_CNT_EN];
                end
                // Software load beats counting and index reset
                `QD_SEL_POS:  st_d.pos  = merge(st_q.pos, st_q.wdata, st_q.wstrb);
                `QD_SEL_PMAX: st_d.pmax = merge(st_q.pmax, st_q.wdata, st_q.wstrb);
                `QD_SEL_STS:
                begin
                    // Write one to clear; a same-cycle set wins
                    if (st_q.wstrb[0] && st_q.wdata[`QD_STS_FIRST] && st_q.first_seen)
                    begin
                        st_d.first_seen = 1'b0;
                    end
                    if (st_q.wstrb[0] && st_q.wdata[`QD_STS_PHERR] && !edge_bad)
                    begin
                        st_d.ph_err = 1'b0;
                    end
                end
                default: st_d.bresp = `QD_RESP_SLVERR;
            endcase
        end
        st_d.awready = !st_d.aw_have && !st_d.bvalid;
        st_d.wready  = !st_d.w_have && !st_d.bvalid;

        // ------------------------------------------------------------
        // AXI4-Lite read path
        // ------------------------------------------------------------
        if (st_q.rvalid && s_axi_rready)
        begin
            st_d.rvalid = 1'b0;
        end
        if (st_q.arready && s_axi_arvalid)
        begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = `QD_RESP_OKAY;
            case (reg_sel(s_axi_araddr))
                `QD_SEL_CTRL: st_d.rdata = ctrl_word;
                `QD_SEL_POS:  st_d.rdata = st_q.pos;
                `QD_SEL_PMAX: st_d.rdata = st_q.pmax;
                `QD_SEL_STS:  st_d.rdata = sts_word;
                default:
                begin
                    st_d.rdata = '0;
                    st_d.rresp = `QD_RESP_SLVERR;
                end
            endcase
        end
        st_d.arready = !st_d.rvalid;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= '0;
        end
        else if (ce)
        begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready = st_q.awready;
    assign s_axi_wready  = st_q.wready;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rresp   = st_q.rresp;
    assign s_axi_rdata   = st_q.rdata;

endmodule

// ===== tb/qdec_props.sv
module qdec_props
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    chk_quiet_reset: assert property (disable iff (1'b0) !aresetn |=>
        !s_axi_awready && !s_axi_arready && !s_axi_bvalid && !s_axi_rvalid) else $error("bus busy after reset");
    chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer not two cycles after");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    chk_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read slot not freed");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    cov_write: cover property (s_axi_awvalid && s_axi_awready);
    cov_read: cover property (s_axi_arvalid && s_axi_arready);
    cov_w_err: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
endmodule

bind quadrature_index_position_reset qdec_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// ===== tb/encoder_model.sv
module encoder_model
(
    input  wire logic aclk,
    input  wire logic step_up,
    input  wire logic step_dn,
    input  wire logic idx_req,
    output logic      phase_a,
    output logic      phase_b,
    output logic      index_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pos_q = 2'h0;
    always_ff @(posedge aclk)
        if (step_up)
            pos_q <= pos_q + 2'h1;
        else if (step_dn)
            pos_q <= pos_q - 2'h1;
    // Gray order, A leads B going forward; never two pins at once
    assign phase_a = pos_q[0] ^ pos_q[1];
    assign phase_b = pos_q[1];
    assign index_in = idx_req;
endmodule

// ===== tb/quadrature_index_position_reset_tb.sv
`include "qdec_defs.svh"
module quadrature_index_position_reset_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
    logic        phase_a, phase_b, index_in, up = 1'h0, dn = 1'h0, idx = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rdat;
    logic [31:0] bres, rres;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          n_fail = 0;
    int          checks_done = 0;

    initial forever #20 aclk = ~aclk;

    quadrature_index_position_reset dut (.aclk, .aresetn, .ce, .phase_a, .phase_b, .index_in,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    encoder_model enc (.aclk, .step_up(up), .step_dn(dn), .idx_req(idx), .phase_a, .phase_b, .index_in);

    // ----------------------------------------------------------------
    // Bus and encoder tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        if (n_fail == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bit ta = 0;
        bit tw = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            ta |= s_axi_awready;
            tw |= s_axi_wready;
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (!(ta && tw));
        // Ready held from the start; the edge seeing bvalid is the handshake
        do @(posedge aclk); while (!s_axi_bvalid);
        bres = {30'h0, s_axi_bresp};
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        rres = {30'h0, s_axi_rresp};
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rc(input logic [3:0] a, input logic [31:0] e, input string nm);
        rd(a);
        chk(nm, rdat, e);
    endtask

    // Each step waits out the two-flop input path
    task automatic mv(input int n, input logic fwd);
        repeat (n)
        begin
            up <= fwd;
            dn <= !fwd;
            @(posedge aclk);
            up <= 1'h0;
            dn <= 1'h0;
            repeat (5) @(posedge aclk);
        end
    endtask

    initial
    begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        finish_test();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        rc(`QD_OFS_CTRL, 32'h0000_0000, "ctrl reset");
        chk("read resp", rres, {30'h0, `QD_RESP_OKAY});
        rc(`QD_OFS_STS, 32'h0000_0000, "status reset");
        rc(`QD_OFS_PMAX, 32'h0000_0000, "pmax reset");
        wr(`QD_OFS_PMAX, 32'h0000_0009);
        chk("write resp", bres, {30'h0, `QD_RESP_OKAY});
        wr(`QD_OFS_CTRL, 32'h0000_0004);
        mv(3, 1'h1);
        rc(`QD_OFS_POS, 32'h0000_0003, "count up");
        mv(1, 1'h0);
        rc(`QD_OFS_POS, 32'h0000_0002, "count down");
        mv(2, 1'h1);
        idx <= 1'h1;
        mv(1, 1'h1);
        idx <= 1'h0;
        rc(`QD_OFS_STS, 32'h0000_0017, "first index status");
        mv(3, 1'h1);
        wr(`QD_OFS_POS, 32'h0000_0007);
        rc(`QD_OFS_POS, 32'h0000_0007, "count write");
        idx <= 1'h1;
        mv(1, 1'h1);
        idx <= 1'h0;
        rc(`QD_OFS_POS, 32'h0000_0000, "forward index reset");
        mv(2, 1'h1);
        idx <= 1'h1;
        mv(1, 1'h0);
        idx <= 1'h0;
        rc(`QD_OFS_POS, 32'h0000_0009, "reverse index load");
        mv(1, 1'h1);
        rc(`QD_OFS_POS, 32'h0000_0000, "wrap up");
        mv(1, 1'h0);
        rc(`QD_OFS_POS, 32'h0000_0009, "wrap down");
        // Reversal inside the pulse hits the stored edge going backwards
        idx <= 1'h1;
        mv(1, 1'h1);
        mv(2, 1'h0);
        idx <= 1'h0;
        rc(`QD_OFS_POS, 32'h0000_0008, "reset on reversal");
        mv(3, 1'h1);
        idx <= 1'h1;
        mv(1, 1'h1);
        idx <= 1'h0;
        rc(`QD_OFS_POS, 32'h0000_0000, "clean index after fault");
        wr(`QD_OFS_STS, 32'h0000_0001);
        rd(`QD_OFS_STS);
        chk("first seen cleared", rdat & 32'h0000_0001, 32'h0000_0000);
        idx <= 1'h1;
        mv(1, 1'h0);
        idx <= 1'h0;
        rc(`QD_OFS_STS, 32'h0000_0001, "rearmed reverse capture");
        wr(`QD_OFS_CTRL, 32'h0000_0005);
        wr(`QD_OFS_POS, 32'h0000_0003);
        idx <= 1'h1;
        mv(1, 1'h1);
        idx <= 1'h0;
        rc(`QD_OFS_POS, 32'h0000_0004, "no index action in wrap mode");
        // Motion while frozen and undone before release leaves no count
        ce <= 1'h0;
        mv(1, 1'h1);
        mv(1, 1'h0);
        ce <= 1'h1;
        rc(`QD_OFS_POS, 32'h0000_0004, "frozen while ce low");
        wr(4'h2, 32'h0000_0001);
        chk("unmapped write resp", bres, {30'h0, `QD_RESP_SLVERR});
        rc(4'h2, 32'h0000_0000, "unmapped read data");
        chk("unmapped read resp", rres, {30'h0, `QD_RESP_SLVERR});
        finish_test();
    end
endmodule
